// ==== prl_eg_partner.sv ====
// Purpose: egress requester standing for frames leaving port two
// Assumes: one frame in flight, request held until the grant edge
// Notes:   released info lines show inverted data, never the last value
`default_nettype none
module prl_eg_partner (
    input  wire logic        ref_clk_i,
    input  wire logic        resetn_i,
    input  wire logic        go_i,
    input  wire logic [10:0] len_i,
    input  wire logic [1:0]  prio_i,
    input  wire logic        grant_i,
    output var  logic        req_o,
    output logic      [10:0] len_o,
    output logic      [1:0]  prio_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [10:0] len_r;
    logic [1:0]  prio_r;

    // request rises on go, falls at the edge that samples the grant
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            req_o  <= 1'b0;
            len_r  <= 11'h000;
            prio_r <= 2'b00;
        end else if (req_o && grant_i) begin
            req_o <= 1'b0;
        end else if (go_i && !req_o) begin
            req_o  <= 1'b1;
            len_r  <= len_i;
            prio_r <= prio_i;
        end
    end

    // released lines inverted so a stale value cannot pass for a live one
    assign len_o  = req_o ? len_r : ~len_r;
    assign prio_o = req_o ? prio_r : ~prio_r;
endmodule // prl_eg_partner
`default_nettype wire

// ==== prl_frame_cost.sv ====
// Purpose: byte cost of one frame for rate accounting
// Assumes: length excludes preamble and gap
// Notes:   combinational
`default_nettype none
module prl_frame_cost
    import prl_pkg::*;
(
    input  wire logic [10:0] len_i,
    input  wire logic        gap_en_i,
    input  wire logic        pre_en_i,
    output var  logic [15:0] cost_o
);
    // ------------------------------------------------------------
    // overhead add
    // ------------------------------------------------------------
    // (RL2) gap bytes added
    // (RL3) preamble bytes added
    always_comb begin
        cost_o = {5'h00, len_i};
        if (gap_en_i) begin
            cost_o = cost_o + PRL_GAP_BYTES;
        end
        if (pre_en_i) begin
            cost_o = cost_o + PRL_PRE_BYTES;
        end
    end
endmodule // prl_frame_cost
`default_nettype wire

// ==== prl_meter_if.sv ====
// Purpose: request and answer bundle between the limiter and its meters
// Assumes: one lane per metered priority or queue
// Notes:   purely combinational signals, no clock inside
`default_nettype none
interface prl_meter_if #(parameter int N = 4);
    logic [N-1:0][6:0] code;
    logic [15:0]       cost;
    logic [N-1:0]      charge;
    logic [N-1:0]      ok;
    modport ctl (output code, output cost, output charge, input ok);
    modport mtr (input code, input cost, input charge, output ok);
endinterface
`default_nettype wire

// ==== prl_pkg.sv ====
// Purpose: shared constants and types for the port two rate limiter
// Assumes: 16-bit host register port, byte addresses, 125 MHz core clock
// Notes:   limit code 0 always means no limiting
`default_nettype none
package prl_pkg;
    // ------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [11:0] PRL_OFF_COUNT_CTRL = 12'h08A;
    localparam logic [11:0] PRL_OFF_ING_LOW    = 12'h08C;
    localparam logic [11:0] PRL_OFF_ING_HIGH   = 12'h08E;
    localparam logic [11:0] PRL_OFF_EG_LOW     = 12'h090;

    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int          PRL_PRE_BIT     = 0;
    localparam int          PRL_GAP_BIT     = 1;
    localparam int          PRL_CLASS_LSB   = 2;
    localparam int          PRL_CTRL_W      = 5;  // bits 15..5 read as zero
    localparam int          PRL_LIM_LO_LSB  = 0;
    localparam int          PRL_LIM_HI_LSB  = 8;
    localparam int          PRL_EG_EN_BIT   = 7;
    localparam int          PRL_CODE_W      = 7;
    localparam logic [15:0] PRL_RST_CTRL    = 16'h0000;
    localparam logic [15:0] PRL_RST_LIMIT   = 16'h0000;
    localparam logic [6:0]  PRL_CODE_NOLIM  = 7'h00;

    // ------------------------------------------------------------
    // per-frame overhead and metering timing
    // ------------------------------------------------------------
    localparam logic [15:0] PRL_GAP_BYTES   = 16'h000C;
    localparam logic [15:0] PRL_PRE_BYTES   = 16'h0008;
    localparam int          PRL_CLK_PS      = 8000;
    localparam int          PRL_REFILL_NS   = 1000;
    localparam int          PRL_REFILL_CYC  = (PRL_REFILL_NS * 1000) / PRL_CLK_PS;
    localparam logic [17:0] PRL_BURST_BYTES = 18'h00800;

    // ingress class selector codes
    typedef enum logic [1:0] {
        PRL_CLS_ALL   = 2'b00,
        PRL_CLS_BMF   = 2'b01,
        PRL_CLS_BM    = 2'b10,
        PRL_CLS_BCAST = 2'b11
    } prl_class_t;

    // egress scheduling states
    typedef enum logic [1:0] {
        PRL_EG_IDLE  = 2'b00,
        PRL_EG_WAIT  = 2'b01,
        PRL_EG_GRANT = 2'b10
    } prl_eg_state_t;

    // code to bytes-per-refill table; entry 0 unused (no limit)
    typedef logic [127:0][15:0] prl_lut_t;

    function automatic prl_lut_t prl_lut_default();
        prl_lut_t t;
        for (int i = 0; i < 128; i++) begin
            t[i] = 16'(i);
        end
        return t;
    endfunction
endpackage
`default_nettype wire

// ==== prl_port_rate_limiter.sv ====
// Purpose: port two ingress policer and egress shaper with its registers
// Assumes: frame descriptors synchronous to ref_clk_i, one at a time
// Notes:   16-bit host register port with byte enables, ack one cycle later
//
// What this block does
// (RL1) two-bit class code picks which ingress frames are counted and limited
// (RL2) gap bit adds 12 bytes per frame to ingress and egress counts
// (RL3) preamble bit adds 8 bytes per frame to ingress and egress counts
// (RL4) priority 0 ingress policed by low word bits 6..0
// (RL5) priority 1 ingress policed by low word bits 14..8
// (RL6) priorities 2 and 3 policed by high word bits 6..0 and 14..8
// (RL7) limit code zero means full rate, no limiting
// (RL8) egress limiting only while egress word bit 7 is set
// (RL9) priority 0 egress paced by egress word bits 6..0
// (RL10) priority 1 egress paced by egress word bits 14..8
// (RL11) single egress queue applies only the priority 0 limit
// (RL12) two queues apply only priority 0 and 1 limits
// (RL13) codes become byte rates through a parameter table
// (RL14) frames outside the selected class pass uncounted
`default_nettype none
module prl_port_rate_limiter
    import prl_pkg::*;
#(
    parameter prl_lut_t RATE_LUT = prl_lut_default()
) (
    input  wire logic        ref_clk_i,
    input  wire logic        resetn_i,
    input  wire logic [11:0] reg_addr_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    input  wire logic [1:0]  reg_be_i,
    input  wire logic [15:0] reg_wdata_i,
    output logic      [15:0] reg_rdata_o,
    output logic             reg_ack_o,
    input  wire logic        ing_valid_i,
    input  wire logic [10:0] ing_len_i,
    input  wire logic [1:0]  ing_prio_i,
    input  wire logic        ing_bcast_i,
    input  wire logic        ing_mcast_i,
    input  wire logic        ing_flood_i,
    output logic             ing_done_o,
    output logic             ing_pass_o,
    input  wire logic        eg_req_i,
    input  wire logic [10:0] eg_len_i,
    input  wire logic [1:0]  eg_prio_i,
    input  wire logic        eg_two_queue_i,
    output logic             eg_grant_o
);
    logic [PRL_CTRL_W-1:0] cnt_ctrl_r;
    logic [15:0]           ing_low_r;
    logic [15:0]           ing_high_r;
    logic [15:0]           eg_low_r;
    logic [15:0]           rd_mux;
    logic                  gap_en;
    logic                  pre_en;
    prl_class_t            cls;
    logic                  ing_sel;
    logic                  ing_ok;
    logic                  eg_en;
    logic                  eg_lane;
    logic                  eg_ok;
    prl_eg_state_t         eg_state_r;
    prl_eg_state_t         eg_state_nxt;

    prl_meter_if #(.N(4)) ing_mif ();
    prl_meter_if #(.N(2)) eg_mif ();

    // ------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------
    // byte-lane write of a 16-bit word
    function automatic logic [15:0] lane_wr(input logic [15:0] old, input logic [15:0] wd,
                                            input logic [1:0] be);
        return {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
    endfunction

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cnt_ctrl_r <= PRL_RST_CTRL[PRL_CTRL_W-1:0];
            ing_low_r  <= PRL_RST_LIMIT;
            ing_high_r <= PRL_RST_LIMIT;
            eg_low_r   <= PRL_RST_LIMIT;
        end else if (reg_wr_i) begin
            case (reg_addr_i)
                // upper bits are read-only zero, only the low byte can land
                PRL_OFF_COUNT_CTRL: begin
                    if (reg_be_i[0]) begin
                        cnt_ctrl_r <= reg_wdata_i[PRL_CTRL_W-1:0];
                    end
                end
                PRL_OFF_ING_LOW:  ing_low_r  <= lane_wr(ing_low_r, reg_wdata_i, reg_be_i);
                PRL_OFF_ING_HIGH: ing_high_r <= lane_wr(ing_high_r, reg_wdata_i, reg_be_i);
                PRL_OFF_EG_LOW:   eg_low_r   <= lane_wr(eg_low_r, reg_wdata_i, reg_be_i);
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // register reads
    // ------------------------------------------------------------
    // unmapped addresses read as zero
    always_comb begin
        case (reg_addr_i)
            PRL_OFF_COUNT_CTRL: rd_mux = {{(16 - PRL_CTRL_W){1'b0}}, cnt_ctrl_r};
            PRL_OFF_ING_LOW:    rd_mux = ing_low_r;
            PRL_OFF_ING_HIGH:   rd_mux = ing_high_r;
            PRL_OFF_EG_LOW:     rd_mux = eg_low_r;
            default:            rd_mux = 16'h0000;
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            reg_rdata_o <= 16'h0000;
            reg_ack_o   <= 1'b0;
        end else begin
            reg_ack_o   <= reg_wr_i | reg_rd_i;
            reg_rdata_o <= reg_rd_i ? rd_mux : 16'h0000;
        end
    end

    // ------------------------------------------------------------
    // control decode
    // ------------------------------------------------------------
    assign gap_en = cnt_ctrl_r[PRL_GAP_BIT];
    assign pre_en = cnt_ctrl_r[PRL_PRE_BIT];
    assign cls    = prl_class_t'(cnt_ctrl_r[PRL_CLASS_LSB +: 2]);
    assign eg_en  = eg_low_r[PRL_EG_EN_BIT];

    // (RL1) class selection
    always_comb begin
        case (cls)
            PRL_CLS_ALL:   ing_sel = 1'b1;
            PRL_CLS_BMF:   ing_sel = ing_bcast_i | ing_mcast_i | ing_flood_i;
            PRL_CLS_BM:    ing_sel = ing_bcast_i | ing_mcast_i;
            PRL_CLS_BCAST: ing_sel = ing_bcast_i;
            default:       ing_sel = 1'b1;
        endcase
    end

    // ------------------------------------------------------------
    // ingress policing
    // ------------------------------------------------------------
    // (RL4) priority 0 code
    assign ing_mif.code[0] = ing_low_r[PRL_LIM_LO_LSB +: PRL_CODE_W];
    // (RL5) priority 1 code
    assign ing_mif.code[1] = ing_low_r[PRL_LIM_HI_LSB +: PRL_CODE_W];
    // (RL6) priority 2 and 3 codes
    assign ing_mif.code[2] = ing_high_r[PRL_LIM_LO_LSB +: PRL_CODE_W];
    assign ing_mif.code[3] = ing_high_r[PRL_LIM_HI_LSB +: PRL_CODE_W];

    assign ing_ok = ing_mif.ok[ing_prio_i];

    // (RL14) unselected frames bypass
    always_comb begin
        ing_mif.charge = 4'h0;
        if (ing_valid_i && ing_sel && ing_ok) begin
            ing_mif.charge[ing_prio_i] = 1'b1;  // dropped frames are not charged
        end
    end

    prl_frame_cost u_ing_cost (
        .len_i    (ing_len_i),
        .gap_en_i (gap_en),
        .pre_en_i (pre_en),
        .cost_o   (ing_mif.cost)
    );

    prl_token_meter #(.N(4), .LUT(RATE_LUT)) u_ing_meter (
        .ref_clk_i (ref_clk_i),
        .resetn_i  (resetn_i),
        .m         (ing_mif.mtr)
    );

    // verdict one cycle after the descriptor
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ing_done_o <= 1'b0;
            ing_pass_o <= 1'b0;
        end else begin
            ing_done_o <= ing_valid_i;
            ing_pass_o <= ing_valid_i & (~ing_sel | ing_ok);
        end
    end

    // ------------------------------------------------------------
    // egress shaping
    // ------------------------------------------------------------
    // (RL11) one queue folds onto lane 0
    // (RL12) two queues use lanes 0 and 1 only
    assign eg_lane = eg_two_queue_i & (eg_prio_i != 2'b00);
    // (RL9) priority 0 pacing code
    assign eg_mif.code[0] = eg_low_r[PRL_LIM_LO_LSB +: PRL_CODE_W];
    // (RL10) priority 1 pacing code
    assign eg_mif.code[1] = eg_two_queue_i ? eg_low_r[PRL_LIM_HI_LSB +: PRL_CODE_W] : PRL_CODE_NOLIM;
    // (RL8) enable gates the shaper
    assign eg_ok = ~eg_en | eg_mif.ok[eg_lane];

    always_comb begin
        eg_mif.charge = 2'b00;
        if (eg_state_r == PRL_EG_WAIT && eg_en && eg_mif.ok[eg_lane]) begin
            eg_mif.charge[eg_lane] = 1'b1;
        end
    end

    prl_frame_cost u_eg_cost (
        .len_i    (eg_len_i),
        .gap_en_i (gap_en),
        .pre_en_i (pre_en),
        .cost_o   (eg_mif.cost)
    );

    prl_token_meter #(.N(2), .LUT(RATE_LUT)) u_eg_meter (
        .ref_clk_i (ref_clk_i),
        .resetn_i  (resetn_i),
        .m         (eg_mif.mtr)
    );

    // holding a frame back is how the transmit rate is limited
    always_comb begin
        case (eg_state_r)
            PRL_EG_IDLE:  eg_state_nxt = eg_req_i ? PRL_EG_WAIT : PRL_EG_IDLE;
            PRL_EG_WAIT:  eg_state_nxt = eg_ok ? PRL_EG_GRANT : PRL_EG_WAIT;
            PRL_EG_GRANT: eg_state_nxt = PRL_EG_IDLE;
            default:      eg_state_nxt = PRL_EG_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            eg_state_r <= PRL_EG_IDLE;
            eg_grant_o <= 1'b0;
        end else begin
            eg_state_r <= eg_state_nxt;
            eg_grant_o <= (eg_state_r == PRL_EG_WAIT) & eg_ok;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    sequence s_eg_start;
        eg_state_r == PRL_EG_IDLE && eg_req_i;
    endsequence

    sequence s_eg_wait_off;
        eg_state_r == PRL_EG_WAIT && !eg_en;
    endsequence

    property p_bcast_only_pass;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        ing_valid_i && cls == PRL_CLS_BCAST && !ing_bcast_i |=> ing_done_o && ing_pass_o;
    endproperty
    a_bcast_only_pass: assert property (p_bcast_only_pass) else $error("unselected frame not passed"); // RL1

    property p_unsel_no_charge;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        ing_valid_i && !ing_sel |-> ing_mif.charge == 4'h0;
    endproperty
    a_unsel_no_charge: assert property (p_unsel_no_charge) else $error("unselected frame charged"); // RL14

    property p_gap_cost;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        gap_en && !pre_en |-> ing_mif.cost == {5'h00, ing_len_i} + 16'h000C;
    endproperty
    a_gap_cost: assert property (p_gap_cost) else $error("gap bytes wrong"); // RL2

    property p_pre_cost;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        pre_en && !gap_en |-> eg_mif.cost == {5'h00, eg_len_i} + 16'h0008;
    endproperty
    a_pre_cost: assert property (p_pre_cost) else $error("preamble bytes wrong"); // RL3

    property p_code_zero_pass;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        ing_valid_i && ing_prio_i == 2'b00 && ing_low_r[6:0] == 7'h00 |=> ing_pass_o;
    endproperty
    a_code_zero_pass: assert property (p_code_zero_pass) else $error("code zero frame dropped"); // RL7

    property p_p0_police;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        ing_valid_i && ing_sel && ing_prio_i == 2'b00 && !ing_mif.ok[0] |=> ing_done_o && !ing_pass_o;
    endproperty
    a_p0_police: assert property (p_p0_police) else $error("over-rate frame passed"); // RL4

    property p_eg_off_grant;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        s_eg_start ##1 s_eg_wait_off |=> eg_grant_o ##1 !eg_grant_o;
    endproperty
    a_eg_off_grant: assert property (p_eg_off_grant) else $error("disabled shaper held frame"); // RL8

    property p_eg_p0_hold;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        eg_state_r == PRL_EG_WAIT && eg_en && !eg_lane && !eg_mif.ok[0] |=> !eg_grant_o;
    endproperty
    a_eg_p0_hold: assert property (p_eg_p0_hold) else $error("grant without credit"); // RL9

    property p_single_queue;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        !eg_two_queue_i |-> eg_mif.charge[1] == 1'b0;
    endproperty
    a_single_queue: assert property (p_single_queue) else $error("lane 1 used in single queue"); // RL11

    property p_two_queue_lane;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        eg_state_r == PRL_EG_WAIT && eg_two_queue_i && eg_en && eg_prio_i != 2'b00 && eg_mif.ok[1]
            |-> eg_mif.charge == 2'b10;
    endproperty
    a_two_queue_lane: assert property (p_two_queue_lane) else $error("high priority not on lane 1"); // RL12
endmodule // prl_port_rate_limiter
`default_nettype wire

// ==== prl_token_meter.sv ====
// Purpose: bank of byte token buckets, one per lane
// Assumes: charge only raised for lanes that answered ok
// Notes:   credit may go negative by one frame; it then blocks until refilled
`default_nettype none
module prl_token_meter
    import prl_pkg::*;
#(
    parameter int       N   = 4,
    parameter prl_lut_t LUT = prl_lut_default()
) (
    input  wire logic ref_clk_i,
    input  wire logic resetn_i,
    prl_meter_if.mtr  m
);
    logic        [7:0]        tick_cnt_r;
    logic                     tick;
    // unpacked so each lane element keeps its sign in compares
    logic signed [17:0]        credit_r   [N];
    logic signed [17:0]        credit_nxt [N];

    // ------------------------------------------------------------
    // refill timebase
    // ------------------------------------------------------------
    assign tick = (tick_cnt_r == 8'(PRL_REFILL_CYC - 1));

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            tick_cnt_r <= 8'h00;
        end else if (tick) begin
            tick_cnt_r <= 8'h00;
        end else begin
            tick_cnt_r <= tick_cnt_r + 8'h01;
        end
    end

    // ------------------------------------------------------------
    // credit update per lane
    // ------------------------------------------------------------
    // (RL13) table lookup per code
    always_comb begin
        for (int i = 0; i < N; i++) begin
            credit_nxt[i] = credit_r[i];
            if (m.code[i] == PRL_CODE_NOLIM) begin
                credit_nxt[i] = PRL_BURST_BYTES;  // (RL7) full rate
            end else begin
                if (tick) begin
                    credit_nxt[i] = credit_nxt[i] + $signed({2'b00, LUT[m.code[i]]});
                end
                if (credit_nxt[i] > $signed(PRL_BURST_BYTES)) begin
                    credit_nxt[i] = PRL_BURST_BYTES;
                end
                if (m.charge[i]) begin
                    credit_nxt[i] = credit_nxt[i] - $signed({2'b00, m.cost});
                end
            end
            m.ok[i] = (m.code[i] == PRL_CODE_NOLIM) || (credit_r[i] > 18'sh00000);
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            credit_r <= '{default: PRL_BURST_BYTES};
        end else begin
            credit_r <= credit_nxt;
        end
    end
endmodule // prl_token_meter
`default_nettype wire

// ==== tb_port_rate_limiter.sv ====
// Purpose: self-checking bench for the port two rate limiter
// Assumes: default table, one byte per refill per code step, 0x800 burst
// Notes:   meters are refilled by reset before every metering case
`default_nettype none
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin error_cnt++; \
    $display("BAD t=%0t got=%h exp=%h", $time, got, exp); end end
module tb_port_rate_limiter
    import prl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        ref_clk_i = 0, resetn_i = 0, wr = 0, rd = 0, ack;
    logic [11:0] addr = '0;
    logic [1:0]  be = '0, iprio = '0, gprio = '0, eprio;
    logic [15:0] wdata = '0, rdata;
    logic        ivalid = 0, ib = 0, im = 0, ifl = 0, idone, ipass;
    logic [10:0] ilen = '0, glen = '0, elen;
    logic        go = 0, ereq, two_q = 0, grant;
    int          error_cnt = 0, checks_done = 0;

    prl_port_rate_limiter dut (
        .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .reg_addr_i(addr), .reg_wr_i(wr),
        .reg_rd_i(rd), .reg_be_i(be), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .reg_ack_o(ack),
        .ing_valid_i(ivalid), .ing_len_i(ilen), .ing_prio_i(iprio), .ing_bcast_i(ib),
        .ing_mcast_i(im), .ing_flood_i(ifl), .ing_done_o(idone), .ing_pass_o(ipass),
        .eg_req_i(ereq), .eg_len_i(elen), .eg_prio_i(eprio), .eg_two_queue_i(two_q),
        .eg_grant_o(grant));
    prl_eg_partner u_peer (
        .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .go_i(go), .len_i(glen), .prio_i(gprio),
        .grant_i(grant), .req_o(ereq), .len_o(elen), .prio_o(eprio));

    // 125 MHz core clock
    always #4 ref_clk_i = ~ref_clk_i;

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // a wait that ran out counts as a mismatch and ends the run
    task automatic hang();
        error_cnt++;
        give_verdict();
    endtask

    // reset also refills every meter, so each case starts from a full burst
    task automatic do_reset();
        @(negedge ref_clk_i);
        resetn_i = 0;
        repeat (16) @(negedge ref_clk_i);
        resetn_i = 1;
        repeat (2) @(negedge ref_clk_i);
    endtask

    task automatic reg_xfer(input logic w, input logic [11:0] a, input logic [1:0] b,
                            input logic [15:0] d, output logic [15:0] q);
        int n;
        @(negedge ref_clk_i);
        wr = w;
        rd = !w;
        addr = a;
        be = b;
        wdata = d;
        @(negedge ref_clk_i);
        wr = 0;
        rd = 0;
        for (n = 0; n < 4 && ack !== 1'b1; n++) @(negedge ref_clk_i);
        if (n == 4) hang();
        q = rdata;
    endtask

    task automatic wr_reg(input logic [11:0] a, input logic [15:0] d);
        logic [15:0] q;
        reg_xfer(1'b1, a, 2'b11, d, q);
    endtask

    // one ingress frame; kind 0 unicast, 1 flooded, 2 multicast, 3 broadcast
    task automatic ing(input int t, input logic [1:0] p, input logic [10:0] len, output logic ok);
        int n;
        @(negedge ref_clk_i);
        ivalid = 1;
        ilen = len;
        iprio = p;
        ib = (t == 3);
        im = (t == 2);
        ifl = (t == 1);
        @(negedge ref_clk_i);
        ivalid = 0;
        for (n = 0; n < 4 && idone !== 1'b1; n++) @(negedge ref_clk_i);
        if (n == 4) hang();
        ok = ipass;
    endtask

    // egress frame through the partner; blocked if no grant in 12 cycles
    task automatic eg(input logic [1:0] p, input logic [10:0] len, output logic got);
        int n;
        @(negedge ref_clk_i);
        go = 1;
        glen = len;
        gprio = p;
        @(negedge ref_clk_i);
        go = 0;
        for (n = 0; n < 12 && grant !== 1'b1; n++) @(negedge ref_clk_i);
        got = (n < 12);
    endtask

    // three frames in a row, bit i is the verdict of frame i
    task automatic burst(input bit egr, input int t, input logic [1:0] p, input logic [10:0] len,
                         output logic [2:0] v);
        for (int i = 0; i < 3; i++) begin
            if (egr) eg(p, len, v[i]);
            else ing(t, p, len, v[i]);
        end
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_regs();
        logic [15:0] q;
        logic [15:0] ex [5] = '{16'h001F, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'h0000};
        do_reset();
        for (int i = 0; i < 5; i++) begin
            reg_xfer(1'b0, 12'h08A + 12'(2 * i), 2'b00, 16'h0000, q);
            `CHK(q, 16'h0000) // reset values, unmapped place reads zero
            wr_reg(12'h08A + 12'(2 * i), 16'hFFFF);
            reg_xfer(1'b0, 12'h08A + 12'(2 * i), 2'b00, 16'h0000, q);
            `CHK(q, ex[i]) // writable bits only, reserved top of control reads zero
        end
        // upper byte lane only: low byte of the limit word must survive
        reg_xfer(1'b1, PRL_OFF_ING_LOW, 2'b10, 16'h0000, q);
        reg_xfer(1'b0, PRL_OFF_ING_LOW, 2'b00, 16'h0000, q);
        `CHK(q, 16'h00FF) // byte enables
        $display("test regs done");
    endtask

    task automatic t_class();
        logic [2:0] v;
        for (int c = 0; c < 4; c++) begin
            for (int t = 0; t < 4; t++) begin
                do_reset();
                wr_reg(PRL_OFF_COUNT_CTRL, 16'(c << 2));
                wr_reg(PRL_OFF_ING_LOW, 16'h0001);
                burst(1'b0, t, 2'd0, 11'd1100, v);
                `CHK(v, (t >= c) ? 3'b011 : 3'b111)
            end
        end
        $display("test class done");
    endtask

    // 1020-byte frames leave 8 bytes of credit only when no overhead is added
    task automatic t_ovh();
        logic [2:0] v;
        for (int o = 0; o < 4; o++) begin
            do_reset();
            wr_reg(PRL_OFF_COUNT_CTRL, 16'(o));
            wr_reg(PRL_OFF_ING_LOW, 16'h0001);
            burst(1'b0, 0, 2'd0, 11'd1020, v);
            `CHK(v, (o == 0) ? 3'b111 : 3'b011)
        end
        $display("test overhead done");
    endtask

    task automatic t_prio();
        logic [2:0] v;
        for (int p = 0; p < 4; p++) begin
            do_reset();
            wr_reg(p[1] ? PRL_OFF_ING_HIGH : PRL_OFF_ING_LOW, p[0] ? 16'h0100 : 16'h0001);
            burst(1'b0, 0, 2'(p), 11'd1100, v);
            `CHK(v, 3'b011)
            burst(1'b0, 0, 2'(p + 1), 11'd1100, v);
            `CHK(v, 3'b111)
        end
        $display("test priority done");
    endtask

    // enable off, prio 0 code, prio 1 code in one and two queue mode, gap
    task automatic t_egress();
        logic [2:0]  v;
        logic [15:0] wv [5] = '{16'h0001, 16'h0081, 16'h0180, 16'h0180, 16'h0081};
        logic [1:0]  pr [5] = '{2'd0, 2'd0, 2'd1, 2'd1, 2'd0};
        logic [2:0]  ex [5] = '{3'b111, 3'b011, 3'b111, 3'b011, 3'b011};
        for (int k = 0; k < 5; k++) begin
            do_reset();
            two_q = (k == 3);
            wr_reg(PRL_OFF_COUNT_CTRL, (k == 4) ? 16'h0002 : 16'h0000);
            wr_reg(PRL_OFF_EG_LOW, wv[k]);
            burst(1'b1, 0, pr[k], (k == 4) ? 11'd1020 : 11'd1100, v);
            `CHK(v, ex[k])
        end
        two_q = 0;
        do_reset();
        $display("test egress done");
    endtask

    // main sequence
    initial begin
        t_regs();
        t_class();
        t_ovh();
        t_prio();
        t_egress();
        give_verdict();
    end
endmodule // tb_port_rate_limiter
`default_nettype wire
